// ---- core/tcr_pkg.sv ----
package tcr_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] TCR_TX_CFG_OFS = 8'h70;
  localparam logic [7:0] TCR_HARDWARE_CONFIGURATION_OFS = 8'h74;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int TCR_TXS_FLUSH_BIT = 15;
  localparam int TCR_TXD_FLUSH_BIT = 14;
  localparam int TCR_OVR_ALLOW_BIT = 2;
  localparam int TCR_TX_ON_BIT = 1;
  localparam int TCR_HALT_BIT = 0;
  localparam int TCR_XOVER_BIT = 24;
  localparam int TCR_MBO_BIT = 20;
  localparam int TCR_ALLOC_LSB = 16;
  localparam int TCR_WIDTH_BIT = 2;
  localparam int TCR_SOFT_RESET_TIMEOUT_BIT = 1;
  localparam int TCR_SOFT_RESET_TRIGGER_BIT = 0;

  // ---------------------------------------------------------------------
  // Reset values and sizes
  // ---------------------------------------------------------------------
  localparam logic [3:0] TCR_ALLOC_RST = 4'h5;
  localparam logic [15:0] TCR_TXS_BYTES = 16'h0200;
  localparam logic [15:0] TCR_TOTAL_BYTES = 16'h4000;
  localparam logic [15:0] TCR_KB_BYTES = 16'h0400;

  // ---------------------------------------------------------------------
  // Soft reset time-out
  // ---------------------------------------------------------------------
  localparam int TCR_CLK_MHZ = 200;
  localparam int TCR_SOFT_RESET_TIMEOUT_US = 10;
  localparam int TCR_SOFT_RESET_TIMEOUT_CYC = TCR_SOFT_RESET_TIMEOUT_US * TCR_CLK_MHZ;

  // Transmitter state.
  typedef enum logic [1:0] {
    TCR_TX_IDLE,
    TCR_TX_SEND,
    TCR_TX_STALL
  } tcr_tx_e;

  // Soft reset state.
  typedef enum logic [1:0] {
    TCR_SR_IDLE,
    TCR_SR_WAIT,
    TCR_SR_DONE
  } tcr_sr_e;

  // Whole module state.
  typedef struct packed {
    logic [1:0] tx_clk_sync;
    logic [1:0] rx_clk_sync;
    logic [1:0] xover_sync;
    logic [1:0] width_sync;
    logic tx_clk_prev;
    logic rx_clk_prev;
    logic [11:0] soft_reset_trigger_cnt;
    logic tx_seen;
    logic rx_seen;
    tcr_tx_e tx_st;
    tcr_sr_e sr_st;
    logic read_seen;
    logic ovr_allow;
    logic tx_on;
    logic halt;
    logic must_be_one;
    logic [3:0] alloc;
    logic xover;
    logic width;
    logic soft_reset_timeout;
    logic txs_flush;
    logic txd_flush;
    logic tx_err;
    logic rx_err;
    logic tx_run;
    logic txs_full_evt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] tx_data_bytes;
    logic [15:0] rx_bytes;
  } tcr_state_s;

endpackage : tcr_pkg

// ---- core/tcr_regs.sv ----
// Register access over APB was decided locally.
`timescale 1ns/1ps
module tcr_regs #(
  parameter int SOFT_RESET_TIMEOUT_CYC = tcr_pkg::TCR_SOFT_RESET_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_active,
  input wire logic frame_end,
  input wire logic txs_full,
  input wire logic tx_err_in,
  input wire logic rx_err_in,
  input wire logic phy_tx_clock,
  input wire logic phy_rx_clock,
  input wire logic crossover_auto_strap,
  input wire logic bus_width_strap,
  output logic tx_run,
  output logic txs_ptr_clear,
  output logic txd_ptr_clear,
  output logic txs_full_event,
  output logic tx_error_flag,
  output logic rx_error_flag,
  output logic [15:0] tx_data_bytes,
  output logic [15:0] rx_bytes
);

  tcr_pkg::tcr_state_s s_q;
  tcr_pkg::tcr_state_s s_d;

  logic acc;
  logic wr;
  logic rd;
  logic hit_tx;
  logic hit_hw;
  logic [15:0] tx_total;

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  // The slave answers in the first access cycle; pready is combinational
  // from the state struct only in the sense that it is registered one
  // cycle after setup, so every access takes exactly one wait-free cycle.
  assign acc = psel && penable && s_q.pready;
  assign wr = acc && pwrite && s_q.read_seen;
  assign rd = acc && !pwrite;
  assign hit_tx = paddr == tcr_pkg::TCR_TX_CFG_OFS;
  assign hit_hw = paddr == tcr_pkg::TCR_HARDWARE_CONFIGURATION_OFS;
  assign tx_total = 16'({12'h000, s_q.alloc} * tcr_pkg::TCR_KB_BYTES);

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  // All state moves in one struct so soft reset can restore it in one
  // place and the exempt fields are spelled out explicitly.
  always_comb begin
    s_d = s_q;
    // Pin inputs pass two flops before any use.
    s_d.tx_clk_sync = {s_q.tx_clk_sync[0], phy_tx_clock};
    s_d.rx_clk_sync = {s_q.rx_clk_sync[0], phy_rx_clock};
    s_d.xover_sync = {s_q.xover_sync[0], crossover_auto_strap};
    s_d.width_sync = {s_q.width_sync[0], bus_width_strap};
    s_d.tx_clk_prev = s_q.tx_clk_sync[1];
    s_d.rx_clk_prev = s_q.rx_clk_sync[1];
    s_d.xover = s_q.xover_sync[1];
    s_d.width = s_q.width_sync[1];
    // Flush pulses last one cycle, then read back as zero.
    s_d.txs_flush = 1'b0;
    s_d.txd_flush = 1'b0;
    // Error flags are sticky; set wins over soft reset clear.
    s_d.tx_err = s_q.tx_err | tx_err_in;
    s_d.rx_err = s_q.rx_err | rx_err_in;
    // Status-full event ignores the overrun-allow setting.
    s_d.txs_full_evt = txs_full;

    // APB answer: ready one cycle after setup.
    s_d.pready = psel && !penable;
    s_d.pslverr = 1'b0;
    if (psel && !penable) begin
      s_d.pslverr = !(paddr == tcr_pkg::TCR_TX_CFG_OFS ||
                      paddr == tcr_pkg::TCR_HARDWARE_CONFIGURATION_OFS);
    end
    if (rd) begin
      s_d.read_seen = 1'b1;
    end

    // Register writes.
    if (wr && hit_tx) begin
      s_d.ovr_allow = pwdata[tcr_pkg::TCR_OVR_ALLOW_BIT];
      s_d.tx_on = pwdata[tcr_pkg::TCR_TX_ON_BIT];
      if (!s_q.halt) begin
        s_d.halt = pwdata[tcr_pkg::TCR_HALT_BIT];
      end
      s_d.txs_flush = pwdata[tcr_pkg::TCR_TXS_FLUSH_BIT];
      s_d.txd_flush = pwdata[tcr_pkg::TCR_TXD_FLUSH_BIT];
    end
    if (wr && hit_hw) begin
      s_d.must_be_one = pwdata[tcr_pkg::TCR_MBO_BIT];
      s_d.alloc = pwdata[tcr_pkg::TCR_ALLOC_LSB +: 4];
      if (pwdata[tcr_pkg::TCR_SOFT_RESET_TRIGGER_BIT] && s_q.sr_st == tcr_pkg::TCR_SR_IDLE)
      begin
        s_d.sr_st = tcr_pkg::TCR_SR_WAIT;
        s_d.soft_reset_trigger_cnt = 12'h000;
        s_d.tx_seen = 1'b0;
        s_d.rx_seen = 1'b0;
        s_d.soft_reset_timeout = 1'b0;
      end
    end

    // Transmitter: frames start only while enabled and not halted.
    case (s_q.tx_st)
      tcr_pkg::TCR_TX_IDLE: begin
        if (s_q.halt) begin
          s_d.halt = 1'b0;
          s_d.tx_on = 1'b0;
        end else if (s_q.tx_on && frame_active) begin
          s_d.tx_st = tcr_pkg::TCR_TX_SEND;
        end
      end
      tcr_pkg::TCR_TX_SEND: begin
        if (txs_full && !s_q.ovr_allow) begin
          s_d.tx_st = tcr_pkg::TCR_TX_STALL;
        end else if (frame_end) begin
          s_d.tx_st = tcr_pkg::TCR_TX_IDLE;
        end
      end
      tcr_pkg::TCR_TX_STALL: begin
        if (!txs_full || s_q.ovr_allow) begin
          s_d.tx_st = tcr_pkg::TCR_TX_SEND;
        end
      end
      default: s_d.tx_st = tcr_pkg::TCR_TX_IDLE;
    endcase
    s_d.tx_run = (s_d.tx_st == tcr_pkg::TCR_TX_SEND) ||
                 (s_d.tx_st == tcr_pkg::TCR_TX_IDLE && s_d.tx_on &&
                  !s_d.halt && (!txs_full || s_d.ovr_allow));

    // Soft reset: both PHY clocks must toggle before the time-out.
    case (s_q.sr_st)
      tcr_pkg::TCR_SR_IDLE: ;
      tcr_pkg::TCR_SR_WAIT: begin
        s_d.soft_reset_trigger_cnt = s_q.soft_reset_trigger_cnt + 12'h001;
        if (s_q.tx_clk_sync[1] != s_q.tx_clk_prev) s_d.tx_seen = 1'b1;
        if (s_q.rx_clk_sync[1] != s_q.rx_clk_prev) s_d.rx_seen = 1'b1;
        if (s_q.tx_seen && s_q.rx_seen) begin
          s_d.sr_st = tcr_pkg::TCR_SR_DONE;
        end else if (32'(s_q.soft_reset_trigger_cnt) >= SOFT_RESET_TIMEOUT_CYC - 1) begin
          s_d.soft_reset_timeout = 1'b1;
          s_d.sr_st = tcr_pkg::TCR_SR_IDLE;
        end
      end
      tcr_pkg::TCR_SR_DONE: begin
        // Control state returns to reset; strap and bus-width latches
        // and the read-seen gate are kept as exempt bits.
        s_d.ovr_allow = 1'b0;
        s_d.tx_on = 1'b0;
        s_d.halt = 1'b0;
        s_d.must_be_one = 1'b0;
        s_d.alloc = tcr_pkg::TCR_ALLOC_RST;
        s_d.tx_st = tcr_pkg::TCR_TX_IDLE;
        s_d.tx_run = 1'b0;
        s_d.txs_flush = 1'b1;
        s_d.txd_flush = 1'b1;
        s_d.tx_err = tx_err_in;
        s_d.rx_err = rx_err_in;
        s_d.sr_st = tcr_pkg::TCR_SR_IDLE;
      end
      default: s_d.sr_st = tcr_pkg::TCR_SR_IDLE;
    endcase

    // FIFO split follows the allocation field.
    s_d.tx_data_bytes = tx_total - tcr_pkg::TCR_TXS_BYTES;
    s_d.rx_bytes = tcr_pkg::TCR_TOTAL_BYTES - tx_total;

    // Read data.
    s_d.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (hit_tx) begin
        s_d.prdata[tcr_pkg::TCR_TXS_FLUSH_BIT] = s_q.txs_flush;
        s_d.prdata[tcr_pkg::TCR_TXD_FLUSH_BIT] = s_q.txd_flush;
        s_d.prdata[tcr_pkg::TCR_OVR_ALLOW_BIT] = s_q.ovr_allow;
        s_d.prdata[tcr_pkg::TCR_TX_ON_BIT] = s_q.tx_on;
        s_d.prdata[tcr_pkg::TCR_HALT_BIT] = s_q.halt;
      end else if (hit_hw) begin
        s_d.prdata[tcr_pkg::TCR_XOVER_BIT] = s_q.xover;
        s_d.prdata[tcr_pkg::TCR_MBO_BIT] = s_q.must_be_one;
        s_d.prdata[tcr_pkg::TCR_ALLOC_LSB +: 4] = s_q.alloc;
        s_d.prdata[tcr_pkg::TCR_WIDTH_BIT] = s_q.width;
        s_d.prdata[tcr_pkg::TCR_SOFT_RESET_TIMEOUT_BIT] = s_q.soft_reset_timeout;
        s_d.prdata[tcr_pkg::TCR_SOFT_RESET_TRIGGER_BIT] =
          s_q.sr_st != tcr_pkg::TCR_SR_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.alloc <= tcr_pkg::TCR_ALLOC_RST;
      // Data share follows the reset allocation minus the status share.
      s_q.tx_data_bytes <= 16'({12'h000, tcr_pkg::TCR_ALLOC_RST} *
                               tcr_pkg::TCR_KB_BYTES) -
                           tcr_pkg::TCR_TXS_BYTES;
      s_q.rx_bytes <= 16'h2C00;
      s_q.tx_st <= tcr_pkg::TCR_TX_IDLE;
      s_q.sr_st <= tcr_pkg::TCR_SR_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign tx_run = s_q.tx_run;
  assign txs_ptr_clear = s_q.txs_flush;
  assign txd_ptr_clear = s_q.txd_flush;
  assign txs_full_event = s_q.txs_full_evt;
  assign tx_error_flag = s_q.tx_err;
  assign rx_error_flag = s_q.rx_err;
  assign tx_data_bytes = s_q.tx_data_bytes;
  assign rx_bytes = s_q.rx_bytes;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  AST_FLUSH_S: assert property (@(posedge ref_clk) disable iff (rst)
    wr && hit_tx && pwdata[15] |=> txs_ptr_clear ##1 !txs_ptr_clear)
    else $error("status flush pulse wrong");
  AST_FLUSH_D: assert property (@(posedge ref_clk) disable iff (rst)
    wr && hit_tx && pwdata[14] |=> txd_ptr_clear)
    else $error("data flush missing");
  AST_STALL: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.tx_st == tcr_pkg::TCR_TX_STALL |-> !s_q.tx_run || s_q.ovr_allow ||
    !txs_full)
    else $error("sent while status full");
  AST_FULLEVT: assert property (@(posedge ref_clk) disable iff (rst)
    txs_full |=> txs_full_event)
    else $error("full event lost");
  AST_IDLEHALT: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.halt && s_q.tx_st == tcr_pkg::TCR_TX_IDLE &&
    s_q.sr_st != tcr_pkg::TCR_SR_DONE |=> !s_q.halt && !s_q.tx_on)
    else $error("idle halt not done");
  AST_HALTHOLD: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.halt && s_q.tx_st != tcr_pkg::TCR_TX_IDLE |=> s_q.halt)
    else $error("halt dropped mid frame");
  AST_NOWRITE: assert property (@(posedge ref_clk) disable iff (rst)
    !s_q.read_seen |=> $stable(s_q.alloc) && $stable(s_q.must_be_one))
    else $error("write before first read");
  AST_TIMEOUT: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.sr_st == tcr_pkg::TCR_SR_WAIT && !s_d.tx_seen &&
    32'(s_q.soft_reset_trigger_cnt) == SOFT_RESET_TIMEOUT_CYC - 1 |=> s_q.soft_reset_timeout)
    else $error("time-out flag not set");
  AST_ERRCLR: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.sr_st == tcr_pkg::TCR_SR_DONE && !tx_err_in |=> !tx_error_flag)
    else $error("error flag survived soft reset");

endmodule : tcr_regs

// ---- bench/tcr_far_model.sv ----
`timescale 1ns/1ps
module tcr_far_model #(
  parameter int FRAME_CYC = 60
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_run,
  input wire logic frame_req,
  input wire logic tx_run,
  output logic frame_active,
  output logic frame_end,
  output logic phy_tx_clock,
  output logic phy_rx_clock
);
  int left;
  // -------------------------------------------------------------------
  // PHY clocks and frame timing
  // -------------------------------------------------------------------
  // The PHY clocks stand still when stopped, so a time-out can occur.
  // A frame only advances while the transmitter is allowed to send.
  always_ff @(posedge ref_clk) begin
    frame_end <= 1'b0;
    if (rst) begin
      phy_tx_clock <= 1'b0;
      phy_rx_clock <= 1'b0;
      frame_active <= 1'b0;
      left <= 0;
    end else begin
      if (clk_run) begin
        phy_tx_clock <= ~phy_tx_clock;
        phy_rx_clock <= ~phy_rx_clock;
      end
      if (frame_req) begin
        frame_active <= 1'b1;
        left <= FRAME_CYC;
      end else if (frame_active && tx_run) begin
        frame_active <= (left != 1);
        frame_end <= (left == 1);
        left <= left - 1;
      end
    end
  end
endmodule : tcr_far_model

// ---- bench/tcr_regs_bench.sv ----
`timescale 1ns/1ps
module tcr_regs_bench;
  // -------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------
  localparam logic [7:0] TXC = 8'h70;
  localparam logic [7:0] HWC = 8'h74;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, txs_full = 1'b0, tx_err_in = 1'b0;
  logic rx_err_in = 1'b0, clk_run = 1'b1, frame_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, frame_active, frame_end, tx_run;
  logic txs_ptr_clear, txd_ptr_clear, txs_full_event;
  logic tx_error_flag, rx_error_flag, phy_tx_clock, phy_rx_clock;
  logic [15:0] tx_data_bytes, rx_bytes;
  int fail_count = 0, total_checks = 0, cycles = 0;
  int pc [2];
  // -------------------------------------------------------------------
  // Design, far side and clock
  // -------------------------------------------------------------------
  tcr_regs #(.SOFT_RESET_TIMEOUT_CYC(20)) dut (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_active(frame_active),
    .frame_end(frame_end), .txs_full(txs_full), .tx_err_in(tx_err_in),
    .rx_err_in(rx_err_in), .phy_tx_clock(phy_tx_clock),
    .phy_rx_clock(phy_rx_clock), .crossover_auto_strap(1'b1),
    .bus_width_strap(1'b1), .tx_run(tx_run),
    .txs_ptr_clear(txs_ptr_clear), .txd_ptr_clear(txd_ptr_clear),
    .txs_full_event(txs_full_event), .tx_error_flag(tx_error_flag),
    .rx_error_flag(rx_error_flag), .tx_data_bytes(tx_data_bytes),
    .rx_bytes(rx_bytes));
  tcr_far_model far (.ref_clk(ref_clk), .rst(rst), .clk_run(clk_run),
    .frame_req(frame_req), .tx_run(tx_run),
    .frame_active(frame_active), .frame_end(frame_end),
    .phy_tx_clock(phy_tx_clock), .phy_rx_clock(phy_rx_clock));
  // The clock toggles every half period of 2.5 ns.
  always #2.5 ref_clk = ~ref_clk;
  // Flush pulses are counted; a hang is cut short by the cycle limit.
  always @(posedge ref_clk) begin
    pc[0] += (txd_ptr_clear === 1'b1);
    pc[1] += (txs_ptr_clear === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  // Reads until a bit reaches a level; the cycle limit catches a hang.
  task automatic poll(input logic [7:0] a, input int b);
    do apb(1'b0, a, 32'h0); while (rd[b] !== 1'b0);
  endtask : poll
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // -------------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    apb(1'b1, TXC, 32'h0000_0002);
    @(posedge ref_clk);
    chk1(tx_run, 1'b0);
    rdchk(TXC, 32'h0000_0000);
    rdchk(HWC, 32'h0105_0004);
    chk({16'h0, tx_data_bytes}, 32'h0000_1200);
    chk({16'h0, rx_bytes}, 32'h0000_2C00);
    chk1(err, 1'b0);
    $display("test reset done");
    for (int a = 2; a <= 14; a++) begin
      apb(1'b1, HWC, 32'h0010_0000 | (32'(a) << 16));
      rdchk(HWC, 32'h0110_0004 | (32'(a) << 16));
      chk(tx_data_bytes, 32'(a * 32'h400 - 32'h200));
      chk(rx_bytes, 32'(32'h4000 - a * 32'h400));
    end
    $display("test allocation done");
    for (int b = 14; b <= 15; b++) begin
      pc = '{0, 0};
      apb(1'b1, TXC, 32'h1 << b);
      repeat (3) @(posedge ref_clk);
      chk(pc[b - 14], 32'h1);
      chk(pc[15 - b], 32'h0);
      rdchk(TXC, 32'h0000_0000);
    end
    $display("test flush done");
    apb(1'b1, TXC, 32'h0000_0002);
    // The run flag is registered on the same edge as the write lands.
    @(posedge ref_clk);
    chk1(tx_run, 1'b1);
    txs_full <= 1'b1;
    frame_req <= 1'b1;
    @(posedge ref_clk);
    frame_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk1(tx_run, 1'b0);
    chk1(txs_full_event, 1'b1);
    apb(1'b1, TXC, 32'h0000_0006);
    // Stall leaves one edge after the allow bit lands, and run rises on that same edge.
    repeat (2) @(posedge ref_clk);
    chk1(tx_run, 1'b1);
    chk1(txs_full_event, 1'b1);
    txs_full <= 1'b0;
    apb(1'b1, TXC, 32'h0000_0007);
    rdchk(TXC, 32'h0000_0007);
    apb(1'b1, TXC, 32'h0000_0006);
    rdchk(TXC, 32'h0000_0007);
    chk1(frame_active, 1'b1);
    poll(TXC, 0);
    chk(rd, 32'h0000_0004);
    chk1(frame_active, 1'b0);
    apb(1'b1, TXC, 32'h0000_0003);
    rdchk(TXC, 32'h0000_0000);
    $display("test transmit done");
    tx_err_in <= 1'b1;
    rx_err_in <= 1'b1;
    @(posedge ref_clk);
    tx_err_in <= 1'b0;
    rx_err_in <= 1'b0;
    apb(1'b1, TXC, 32'h0000_0004);
    chk1(tx_error_flag & rx_error_flag, 1'b1);
    apb(1'b1, HWC, 32'h0000_0001);
    poll(HWC, 0);
    chk(rd, 32'h0105_0004);
    chk1(tx_error_flag | rx_error_flag, 1'b0);
    rdchk(TXC, 32'h0000_0000);
    $display("test soft reset done");
    apb(1'b1, HWC, 32'h0017_0000);
    clk_run <= 1'b0;
    apb(1'b1, HWC, 32'h0017_0001);
    poll(HWC, 0);
    chk(rd, 32'h0117_0006);
    clk_run <= 1'b1;
    apb(1'b1, HWC, 32'h0000_0001);
    poll(HWC, 0);
    chk(rd & 32'h00FF_0001, 32'h0005_0000);
    $display("test time-out done");
    apb(1'b1, 8'h78, 32'hFFFF_FFFF);
    chk1(err, 1'b1);
    apb(1'b0, 8'h00, 32'h0);
    chk1(err, 1'b1);
    rdchk(TXC, 32'h0000_0000);
    $display("test unmapped done");
    complete_run();
  end
endmodule : tcr_regs_bench
